//--- bench/clock_source_startup_and_rc_trim_tb.sv
/*
  self-checking bench for the clock source and start-up sequencer: runs 14
  fuse settings through reset and wake, then exercises the trim register.
  assumes the shortened delay parameters below and a 10 mhz clock.
*/
`timescale 1ns/100ps
module clock_source_startup_and_rc_trim_tb;
  localparam int D41 = 50;                     // shortened 4.1 ms
  localparam int D65 = 90;                     // shortened 65 ms
  localparam int D4  = 45;                     // shortened 4 ms
  localparam int D64 = 85;                     // shortened 64 ms
  localparam int W32 = 40;                     // shortened 32k wake
  logic                     clk_i      = 1'b0; // block clock
  logic                     rst_i      = 1'b1; // synchronous reset
  logic                     ce_i       = 1'b1; // clock enable
  clk_startup_pkg::wb_req_t wb_i       = '0;   // bus request
  clk_startup_pkg::wb_rsp_t wb_o;              // bus answer
  logic [3:0]               src_fuses  = 4'h2; // source fuses
  logic [1:0]               sut_fuses  = 2'h0; // start-up fuses
  logic                     rdis_fuse  = 1'b0; // reset pin disable fuse
  logic [7:0]               factory    = 8'h5a; // calibration byte
  logic                     wake_req_i = 1'b0; // wake pulse
  logic                     sys_rst_o, cpu_clk_en_o, rc_osc_en_o, lf_osc_en_o;
  logic                     khz_osc_en_o, wdt_osc_en_o, trim_range_o, fuse_err_o;
  clk_startup_pkg::source_t src_o;             // selected source
  logic [7:0]               trim_o;            // trim register
  logic [6:0]               trim_fine_o;       // fine field
  logic [15:0]              freq;              // model frequency
  logic [15:0]              f_hi;              // frequency at 0x7f
  logic [31:0]              q;                 // read data
  int                       err_total  = 0;    // mismatches
  int                       n_compared = 0;    // comparisons
  // free-running clock, 100 ns period
  always #50 clk_i = ~clk_i;
  clk_startup #(.WAKE_32K_CYC(20'(W32)), .DLY_4P1_CYC(20'(D41)), .DLY_65_CYC(20'(D65)),
    .DLY_4_CYC(20'(D4)), .DLY_64_CYC(20'(D64))) uut (.clk_i(clk_i), .rst_i(rst_i),
    .ce_i(ce_i), .wb_i(wb_i), .wb_o(wb_o), .clock_source_select_fuses_i(src_fuses),
    .startup_time_fuses_i(sut_fuses), .reset_pin_disable_fuse_i(rdis_fuse),
    .factory_trim_i(factory), .wake_req_i(wake_req_i), .sys_rst_o(sys_rst_o),
    .cpu_clk_en_o(cpu_clk_en_o), .src_o(src_o), .rc_osc_en_o(rc_osc_en_o),
    .lf_osc_en_o(lf_osc_en_o), .khz_osc_en_o(khz_osc_en_o), .wdt_osc_en_o(wdt_osc_en_o),
    .trim_o(trim_o), .trim_range_o(trim_range_o), .trim_fine_o(trim_fine_o),
    .fuse_err_o(fuse_err_o));
  rc_osc_model osc (.rc_osc_en_i(rc_osc_en_o), .trim_range_i(trim_range_o),
    .trim_fine_i(trim_fine_o), .freq_khz_o(freq), .mem_write_ok_o());
  // compare and count; unknowns never match
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // counts, verdict, end of run
  task automatic test_done;
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // one classic cycle: hold until ack is sampled, then release
  task automatic wb_xfer(input logic we, input logic [7:0] a, input logic [3:0] s,
                         input logic [31:0] d, output logic [31:0] r);
    int n;
    n = 0;
    @(posedge clk_i);
    wb_i <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: a, sel: s, dat: d};
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_o.ack !== 1'b1 && n < 20);
    r = wb_o.dat;
    wb_i <= '0;
    if (n >= 20) chk("ack", 1'b0, 1'b1);
  endtask
  // enables expected for a source: {crystal, rc, 128k}
  function automatic logic [2:0] osc_exp(input clk_startup_pkg::source_t s);
    case (s)
      clk_startup_pkg::SRC_LF_XTAL: osc_exp = 3'h4;
      clk_startup_pkg::SRC_KHZ128:  osc_exp = 3'h1;
      // rc source, and rc kept running when no source is valid
      default:                      osc_exp = 3'h2;
    endcase
  endfunction
  // reset with one fuse setting, time the reset delay, then one wake
  task automatic run_cfg(input logic [3:0] f, input logic [1:0] s, input logic d,
                         input int extra, input int wake);
    int n;
    clk_startup_pkg::source_t es;
    es = (f == 4'h2) ? clk_startup_pkg::SRC_RC_OSC :
         (f == 4'h3) ? clk_startup_pkg::SRC_KHZ128 :
         (f[3:1] == 3'h2) ? clk_startup_pkg::SRC_LF_XTAL : clk_startup_pkg::SRC_NONE;
    @(posedge clk_i);
    src_fuses <= f;
    sut_fuses <= s;
    rdis_fuse <= d;
    factory   <= {f, 2'h1, s} ^ 8'ha5;
    rst_i     <= 1'b1;
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    @(negedge clk_i);
    chk("trim_rst", trim_o, factory);
    n = 0;
    // count cycles with internal reset still held
    while (sys_rst_o === 1'b1 && n < 2000) begin
      n++;
      @(negedge clk_i);
    end
    chk("rst_len", n, 14 + extra);
    chk("run_clk", cpu_clk_en_o, 1'b1);
    chk("src", src_o, es);
    chk("osc_en", {lf_osc_en_o, rc_osc_en_o, khz_osc_en_o}, osc_exp(es));
    chk("wdt_en", wdt_osc_en_o, es == clk_startup_pkg::SRC_RC_OSC);
    chk("fuse_err", fuse_err_o, (s == 2'h3) || (es == clk_startup_pkg::SRC_NONE));
    @(posedge clk_i);
    wake_req_i <= 1'b1;
    @(posedge clk_i);
    wake_req_i <= 1'b0;
    n = 0;
    @(negedge clk_i);
    // count gated cycles after the wake pulse
    while (cpu_clk_en_o === 1'b0 && n < 40000) begin
      n++;
      @(negedge clk_i);
    end
    chk("wake_len", n, wake);
    $display("test fuses %h sut %h rdis %b done", f, s, d);
  endtask
  // main sequence
  initial begin
    run_cfg(4'h2, 2'h0, 1'b0, 0, 6);
    run_cfg(4'h2, 2'h1, 1'b0, D41, 6);
    run_cfg(4'h2, 2'h2, 1'b0, D65, 6);
    run_cfg(4'h2, 2'h0, 1'b1, D41, 6);
    run_cfg(4'h3, 2'h0, 1'b0, 0, 6);
    run_cfg(4'h3, 2'h1, 1'b0, D4, 6);
    run_cfg(4'h3, 2'h2, 1'b0, D64, 6);
    run_cfg(4'h3, 2'h0, 1'b1, D41, 6);
    // short crystal start, acceptable here as stability is not checked
    run_cfg(4'h4, 2'h0, 1'b1, 0, 1024);
    run_cfg(4'h5, 2'h1, 1'b0, D41, W32);
    run_cfg(4'h5, 2'h2, 1'b0, D65, W32);
    run_cfg(4'h2, 2'h3, 1'b0, D65, 6);
    // unknown source code: rc kept on, error flagged, pin fuse still lengthens
    run_cfg(4'h0, 2'h0, 1'b1, D41, 6);
    run_cfg(4'h2, 2'h1, 1'b1, D41, 6);
    // trim register: boundary values, masked write, unmapped and status
    wb_xfer(1'b1, 8'h00, 4'h1, 32'h0000007f, q);
    chk("trim_w", trim_o, 8'h7f);
    chk("range", trim_range_o, 1'b0);
    chk("fine", trim_fine_o, 7'h7f);
    f_hi = freq;
    wb_xfer(1'b1, 8'h00, 4'hf, 32'hffffff80, q);
    chk("range_hi", trim_range_o, 1'b1);
    chk("overlap", f_hi > freq, 1'b1);
    wb_xfer(1'b1, 8'h00, 4'he, 32'h00000011, q);
    wb_xfer(1'b0, 8'h00, 4'hf, 32'h0, q);
    chk("trim_r", q, 32'h00000080);
    wb_xfer(1'b0, 8'h10, 4'hf, 32'h0, q);
    chk("unmapped", q, 32'h0);
    wb_xfer(1'b1, 8'h04, 4'hf, 32'hffffffff, q);
    wb_xfer(1'b0, 8'h04, 4'hf, 32'h0, q);
    chk("status", q, 32'h0000009a);
    // low clock enable freezes the sequencer: a wake pulse then is not taken
    @(posedge clk_i);
    ce_i       <= 1'b0;
    wake_req_i <= 1'b1;
    @(posedge clk_i);
    wake_req_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    ce_i <= 1'b1;
    @(negedge clk_i);
    chk("ce_freeze", cpu_clk_en_o, 1'b1);
    $display("test trim register done");
    test_done;
  end
  // watchdog against a hang
  initial begin
    repeat (60000) @(posedge clk_i);
    err_total++;
    $display("watchdog expired");
    test_done;
  end
endmodule // clock_source_startup_and_rc_trim_tb

//--- bench/rc_osc_model.sv
/*
  behavioural partner for the rc oscillator: turns the trim outputs into a
  nominal frequency and flags trims slow enough for memory writes.
  assumes the trim fields come straight from the sequencer registers.
*/
`timescale 1ns/100ps
module rc_osc_model (
  input  wire logic        rc_osc_en_i,    // oscillator running
  input  wire logic        trim_range_i,   // range select bit
  input  wire logic [6:0]  trim_fine_i,    // fine tune field
  output logic      [15:0] freq_khz_o,     // nominal frequency, 0 when stopped
  output logic             mem_write_ok_o  // trim slow enough for memory writes
);
  // overlapping ranges: top of the low range lies above the high range floor
  always_comb begin
    if (!rc_osc_en_i) begin
      freq_khz_o = 16'h0000;
    end else if (trim_range_i) begin
      freq_khz_o = 16'd7000 + 16'(trim_fine_i) * 16'd30;
    end else begin
      freq_khz_o = 16'd5200 + 16'(trim_fine_i) * 16'd30;
    end
  end
  // software must stay below this while memories are written
  assign mem_write_ok_o = (freq_khz_o <= 16'd8800);
endmodule // rc_osc_model

//--- hdl/clk_startup.sv
/*
  Clock source selection and start-up sequencer with the RC oscillator trim
  register, reached over a classic wishbone slave.
  Assumes fuse inputs are static and on this clock, clk_i keeps running as
  the watchdog time base through reset, and wake_req_i is a one-cycle pulse.
*/
// Our own choices: the placing of the registers and the Wishbone slave port.
`timescale 1ns/100ps
`include "clk_startup_consts.svh"

module clk_startup #(
  parameter logic [19:0] WAKE_32K_CYC = 20'(`WAKE_32K_CK),
  parameter logic [19:0] DLY_4P1_CYC  = 20'((`T_4P1MS_NS + `CLK_NS - 1) / `CLK_NS),
  parameter logic [19:0] DLY_65_CYC   = 20'((`T_65MS_NS + `CLK_NS - 1) / `CLK_NS),
  parameter logic [19:0] DLY_4_CYC    = 20'((`T_4MS_NS + `CLK_NS - 1) / `CLK_NS),
  parameter logic [19:0] DLY_64_CYC   = 20'((`T_64MS_NS + `CLK_NS - 1) / `CLK_NS)
) (
  input  wire logic                     clk_i,
  input  wire logic                     rst_i,
  input  wire logic                     ce_i,
  input  wire clk_startup_pkg::wb_req_t wb_i,
  output clk_startup_pkg::wb_rsp_t      wb_o,
  input  wire logic [3:0]               clock_source_select_fuses_i,
  input  wire logic [1:0]               startup_time_fuses_i,
  input  wire logic                     reset_pin_disable_fuse_i,
  input  wire logic [7:0]               factory_trim_i,
  input  wire logic                     wake_req_i,
  output logic                          sys_rst_o,
  output logic                          cpu_clk_en_o,
  output clk_startup_pkg::source_t      src_o,
  output logic                          rc_osc_en_o,
  output logic                          lf_osc_en_o,
  output logic                          khz_osc_en_o,
  output logic                          wdt_osc_en_o,
  output logic [7:0]                    trim_o,
  output logic                          trim_range_o,
  output logic [6:0]                    trim_fine_o,
  output logic                          fuse_err_o
);

  clk_startup_pkg::state_t  st;        // registered state
  clk_startup_pkg::state_t  next_st;   // next state
  logic [19:0]              ms_cyc;    // extra reset delay in cycles
  logic [19:0]              wake_cyc;  // wake-up cycle count
  logic [31:0]              status;    // status word as read
  logic                     bus_req;   // new bus request this cycle

  // fuse code to source; unknown codes give no source and flag an error
  function automatic clk_startup_pkg::source_t decode_src(input logic [3:0] f);
    clk_startup_pkg::source_t s;
    s = clk_startup_pkg::SRC_NONE;
    if (f == `SRC_RC_CODE) begin
      s = clk_startup_pkg::SRC_RC_OSC;
    end else if (f == `SRC_128K_CODE) begin
      s = clk_startup_pkg::SRC_KHZ128;
    end else if (f[3:1] == `SRC_LF_CODE) begin
      s = clk_startup_pkg::SRC_LF_XTAL;
    end
    return s;
  endfunction

  // extra reset delay chosen by the captured fuses
  always_comb begin
    ms_cyc = '0;
    case (st.startup_time_fuses)
      `SUT_FAST: begin
        // the 128 kHz source has its own rounder figure
        ms_cyc = (st.src == clk_startup_pkg::SRC_KHZ128) ? DLY_4_CYC : DLY_4P1_CYC;
      end
      `SUT_SLOW, `SUT_RESERVED: begin
        // reserved code falls back to the slow setting, safest choice
        ms_cyc = (st.src == clk_startup_pkg::SRC_KHZ128) ? DLY_64_CYC : DLY_65_CYC;
      end
      default: begin
        // shortest code; lengthened when the reset pin is gone, except on the watch crystal
        if (st.rst_dis && st.src != clk_startup_pkg::SRC_LF_XTAL) begin
          ms_cyc = DLY_4P1_CYC;
        end
      end
    endcase
  end

  // wake-up count from power-down and power-save
  always_comb begin
    wake_cyc = `WAKE_SHORT_CK;
    if (st.src == clk_startup_pkg::SRC_LF_XTAL) begin
      wake_cyc = st.low_sel ? WAKE_32K_CYC : `WAKE_1K_CK;
    end
  end

  // status word assembly
  always_comb begin
    status = '0;
    status[`STAT_PHASE_LSB +: 2] = st.phase;
    status[`STAT_SRC_LSB +: 2]   = st.src;
    status[`STAT_SUT_LSB +: 2]   = st.startup_time_fuses;
    status[`STAT_LOWSEL_BIT]     = st.low_sel;
    status[`STAT_RSTDIS_BIT]     = st.rst_dis;
    status[`STAT_ERR_BIT]        = st.fuse_err;
  end

  // a request is taken once; ack blocks the next cycle
  assign bus_req = wb_i.cyc && wb_i.stb && !st.ack;

  // next state: bus slave, sequencer, then reset load
  always_comb begin
    next_st     = st;
    next_st.ack = 1'b0;
    // bus slave, one cycle to ack
    if (bus_req) begin
      next_st.ack = 1'b1;
      next_st.dat = '0;
      case (wb_i.adr)
        `ADR_TRIM: begin
          next_st.dat = {24'h000000, st.trim};
          if (wb_i.we && wb_i.sel[0]) begin
            next_st.trim = wb_i.dat[7:0];
          end
        end
        `ADR_STATUS: begin
          // read only; writes are dropped
          next_st.dat = status;
        end
        default: begin
          // unmapped: ack with zero, nothing stored
          next_st.dat = '0;
        end
      endcase
    end
    // start-up sequencer
    case (st.phase)
      clk_startup_pkg::ST_RST_CK: begin
        // fixed cycle part of the reset delay
        if (st.cnt == '0) begin
          if (ms_cyc == '0) begin
            next_st.phase = clk_startup_pkg::ST_RUN;
          end else begin
            next_st.phase = clk_startup_pkg::ST_RST_MS;
            next_st.cnt   = ms_cyc - 20'h00001;
          end
        end else begin
          next_st.cnt = st.cnt - 20'h00001;
        end
      end
      clk_startup_pkg::ST_RST_MS: begin
        // time-out part, counted on the watchdog time base
        if (st.cnt == '0) begin
          next_st.phase = clk_startup_pkg::ST_RUN;
        end else begin
          next_st.cnt = st.cnt - 20'h00001;
        end
      end
      clk_startup_pkg::ST_RUN: begin
        // a wake pulse gates the core while the oscillator settles
        if (wake_req_i) begin
          next_st.phase = clk_startup_pkg::ST_WAKE;
          next_st.cnt   = wake_cyc - 20'h00001;
        end
      end
      clk_startup_pkg::ST_WAKE: begin
        // wake pulses here are absorbed, the count is not restarted
        if (st.cnt == '0) begin
          next_st.phase = clk_startup_pkg::ST_RUN;
        end else begin
          next_st.cnt = st.cnt - 20'h00001;
        end
      end
      default: begin
        next_st.phase = clk_startup_pkg::ST_RST_CK;
      end
    endcase
    // reset: capture fuses and reload the factory trim
    if (rst_i) begin
      next_st          = '0;
      next_st.phase    = clk_startup_pkg::ST_RST_CK;
      next_st.cnt      = `BASE_CK - 20'h00001;
      next_st.trim     = factory_trim_i;
      next_st.src      = decode_src(clock_source_select_fuses_i);
      next_st.startup_time_fuses      = startup_time_fuses_i;
      next_st.low_sel  = clock_source_select_fuses_i[0];
      next_st.rst_dis  = reset_pin_disable_fuse_i;
      next_st.fuse_err = (decode_src(clock_source_select_fuses_i) == clk_startup_pkg::SRC_NONE)
                      || (startup_time_fuses_i == `SUT_RESERVED);
    end
  end

  // state register; reset wins over a low clock enable
  always_ff @(posedge clk_i) begin
    if (rst_i || ce_i) begin
      st <= next_st;
    end
  end

  // outputs, all decoded from registered state
  assign wb_o.ack     = st.ack;
  assign wb_o.dat     = st.dat;
  assign sys_rst_o    = (st.phase == clk_startup_pkg::ST_RST_CK)
                     || (st.phase == clk_startup_pkg::ST_RST_MS);
  assign cpu_clk_en_o = (st.phase == clk_startup_pkg::ST_RUN);
  assign src_o        = st.src;
  // no valid source: run on RC so the part can still be reached
  assign rc_osc_en_o  = (st.src == clk_startup_pkg::SRC_RC_OSC)
                     || (st.src == clk_startup_pkg::SRC_NONE);
  assign lf_osc_en_o  = (st.src == clk_startup_pkg::SRC_LF_XTAL);
  assign khz_osc_en_o = (st.src == clk_startup_pkg::SRC_KHZ128);
  // watchdog oscillator stays on under RC and during the time-out
  assign wdt_osc_en_o = (st.src == clk_startup_pkg::SRC_RC_OSC)
                     || (st.phase == clk_startup_pkg::ST_RST_MS);
  assign trim_o       = st.trim;
  assign trim_range_o = st.trim[`TRIM_RANGE_BIT];
  assign trim_fine_o  = st.trim[6:0];
  assign fuse_err_o   = st.fuse_err;

  // checking helpers: elapsed reset and wake cycles
  logic [20:0] rst_el;   // enabled cycles spent in reset phases
  logic [19:0] wk_el;    // enabled cycles spent in wake phase
  logic [20:0] exp_rst;  // expected reset length from raw fuses
  logic [19:0] exp_ms;   // expected extra delay from raw fuses
  logic        f_lf;     // raw fuses pick the watch crystal
  logic        f_128;    // raw fuses pick the 128 kHz source

  assign f_lf  = (clock_source_select_fuses_i[3:1] == `SRC_LF_CODE);
  assign f_128 = (clock_source_select_fuses_i == `SRC_128K_CODE);

  // expected delay worked out straight from the fuse pins
  always_comb begin
    exp_ms = '0;
    if (startup_time_fuses_i == `SUT_FAST) begin
      exp_ms = f_128 ? DLY_4_CYC : DLY_4P1_CYC;
    end else if (startup_time_fuses_i[1]) begin
      exp_ms = f_128 ? DLY_64_CYC : DLY_65_CYC;
    end else if (reset_pin_disable_fuse_i && !f_lf) begin
      exp_ms = DLY_4P1_CYC;
    end
    exp_rst = 21'(`BASE_CK) + 21'(exp_ms);
  end

  // elapsed counters, frozen with the clock enable like the block
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rst_el <= '0;
      wk_el  <= '0;
    end else if (ce_i) begin
      if (sys_rst_o) begin
        rst_el <= rst_el + 21'h000001;
      end
      wk_el <= (st.phase == clk_startup_pkg::ST_WAKE) ? wk_el + 20'h00001 : '0;
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // first cycle after reset release
  sequence s_released;
    $past(rst_i);
  endsequence

  // a write to the trim register taken this cycle
  sequence s_trim_wr;
    ce_i && bus_req && wb_i.we && wb_i.sel[0] && (wb_i.adr == `ADR_TRIM);
  endsequence

  // last enabled cycle of a wake phase
  sequence s_wake_end;
    ce_i && (st.phase == clk_startup_pkg::ST_WAKE) && (st.cnt == '0);
  endsequence

  property p_lf_reset;
    $fell(sys_rst_o) && (src_o == clk_startup_pkg::SRC_LF_XTAL) |-> rst_el == exp_rst;
  endproperty
  a_lf_reset: assert property (p_lf_reset) else $error("crystal reset delay wrong");

  property p_lf_wake;
    s_wake_end and (src_o == clk_startup_pkg::SRC_LF_XTAL)
      |-> 20'(wk_el + 20'h00001) == (st.low_sel ? WAKE_32K_CYC : `WAKE_1K_CK);
  endproperty
  a_lf_wake: assert property (p_lf_wake) else $error("crystal wake count wrong");

  property p_rc_select;
    s_released and ($past(clock_source_select_fuses_i) == `SRC_RC_CODE)
      |-> (src_o == clk_startup_pkg::SRC_RC_OSC) && rc_osc_en_o && !khz_osc_en_o;
  endproperty
  a_rc_select: assert property (p_rc_select) else $error("RC source not selected");

  property p_trim_load;
    s_released |-> (trim_o == $past(factory_trim_i)) && sys_rst_o;
  endproperty
  a_trim_load: assert property (p_trim_load) else $error("factory trim not loaded");

  property p_rc_reset;
    $fell(sys_rst_o) && (src_o == clk_startup_pkg::SRC_RC_OSC) |-> rst_el == exp_rst;
  endproperty
  a_rc_reset: assert property (p_rc_reset) else $error("RC reset delay wrong");

  property p_short_wake;
    s_wake_end and (src_o != clk_startup_pkg::SRC_LF_XTAL) |-> wk_el == 20'h00005;
  endproperty
  a_short_wake: assert property (p_short_wake) else $error("six cycle wake wrong");

  property p_rstdis;
    $fell(sys_rst_o) && st.rst_dis && (st.startup_time_fuses == `SUT_SHORT)
      && (src_o != clk_startup_pkg::SRC_LF_XTAL) |-> rst_el == 21'(`BASE_CK) + 21'(DLY_4P1_CYC);
  endproperty
  a_rstdis: assert property (p_rstdis) else $error("reset pin fuse not lengthening");

  // judged from outputs and the elapsed count, not from the enable's own terms
  property p_wdt_on;
    (rc_osc_en_o && (src_o != clk_startup_pkg::SRC_NONE)) || (sys_rst_o && (rst_el >= 21'(`BASE_CK)))
      |-> wdt_osc_en_o;
  endproperty
  a_wdt_on: assert property (p_wdt_on) else $error("watchdog oscillator dropped");

  property p_trim_write;
    s_trim_wr |=> (trim_o == $past(wb_i.dat[7:0])) && wb_o.ack ##1 !wb_o.ack;
  endproperty
  a_trim_write: assert property (p_trim_write) else $error("trim write lost");

  property p_trim_fields;
    {trim_range_o, trim_fine_o} == trim_o;
  endproperty
  a_trim_fields: assert property (p_trim_fields) else $error("trim fields split wrong");

  property p_khz_select;
    s_released and ($past(clock_source_select_fuses_i) == `SRC_128K_CODE)
      |-> (src_o == clk_startup_pkg::SRC_KHZ128) && khz_osc_en_o && !rc_osc_en_o;
  endproperty
  a_khz_select: assert property (p_khz_select) else $error("128 kHz source not selected");

  property p_khz_reset;
    $fell(sys_rst_o) && (src_o == clk_startup_pkg::SRC_KHZ128) |-> rst_el == exp_rst;
  endproperty
  a_khz_reset: assert property (p_khz_reset) else $error("128 kHz reset delay wrong");

  property p_hold;
    sys_rst_o || (st.phase == clk_startup_pkg::ST_WAKE) |-> !cpu_clk_en_o;
  endproperty
  a_hold: assert property (p_hold) else $error("core clocked during start-up");

  property p_short_reset;
    s_released and (exp_rst == 21'(`BASE_CK)) |-> sys_rst_o [*8] ##1 sys_rst_o [*6] ##1 !sys_rst_o;
  endproperty
  a_short_reset: assert property (p_short_reset) else $error("14 cycle reset wrong");

endmodule // clk_startup

//--- hdl/clk_startup_consts.svh
/*
  Constants for the clock source and start-up sequencer: register offsets,
  status fields, fuse codes, start-up cycle counts and reset delay times.
  Assumes a 10 MHz block clock (100 ns period) and a 32-bit wishbone bus.
*/
// Overview of operation
// - watch crystal: 1k/32k wake, 14CK plus ms reset
// - source fuses 0010 select calibrated RC oscillator
// - every reset loads factory byte into trim
// - RC source: 6CK wake, 14CK plus ms reset
// - reset pin disabled: code 00 gets 4.1 ms, except on the watch crystal
// - watchdog oscillator times reset while RC runs
// - trim register readable, writable, retunes oscillator
// - top trim bit picks low or high range
// - low seven trim bits tune within range
// - source fuses 0011 select 128 kHz oscillator
// - 128 kHz source: 6CK wake, 14CK plus ms reset
`ifndef CLK_STARTUP_CONSTS_SVH
`define CLK_STARTUP_CONSTS_SVH
`define CLK_NS          100
`define T_4P1MS_NS      4100000
`define T_65MS_NS       65000000
`define T_4MS_NS        4000000
`define T_64MS_NS       64000000
`define BASE_CK         20'h0000e
`define WAKE_SHORT_CK   20'h00006
`define WAKE_1K_CK      20'h00400
`define WAKE_32K_CK     32768
`define SRC_RC_CODE     4'h2
`define SRC_128K_CODE   4'h3
`define SRC_LF_CODE     3'h2
`define SUT_SHORT       2'h0
`define SUT_FAST        2'h1
`define SUT_SLOW        2'h2
`define SUT_RESERVED    2'h3
`define ADR_TRIM        8'h00
`define ADR_STATUS      8'h04
`define TRIM_RANGE_BIT  7
`define STAT_PHASE_LSB  0
`define STAT_SRC_LSB    2
`define STAT_SUT_LSB    4
`define STAT_LOWSEL_BIT 6
`define STAT_RSTDIS_BIT 7
`define STAT_ERR_BIT    8
`endif

//--- hdl/clk_startup_pkg.sv
/*
  Types for the clock source and start-up sequencer: phases, sources,
  wishbone carriers and the packed state of the block.
  Assumes the constants header is included by the design file.
*/
package clk_startup_pkg;
  // sequencer phases
  typedef enum logic [1:0] {ST_RST_CK, ST_RST_MS, ST_RUN, ST_WAKE} phase_t;
  // selected system clock source
  typedef enum logic [1:0] {SRC_NONE, SRC_LF_XTAL, SRC_RC_OSC, SRC_KHZ128} source_t;
  // wishbone request from the master
  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [7:0]  adr;
    logic [3:0]  sel;
    logic [31:0] dat;
  } wb_req_t;
  // wishbone answer to the master
  typedef struct packed {
    logic        ack;
    logic [31:0] dat;
  } wb_rsp_t;
  // whole state of the block
  typedef struct packed {
    phase_t      phase;
    logic [19:0] cnt;
    logic [7:0]  trim;
    source_t     src;
    logic [1:0]  startup_time_fuses;
    logic        low_sel;
    logic        rst_dis;
    logic        fuse_err;
    logic        ack;
    logic [31:0] dat;
  } state_t;
endpackage
